// ### common/scs_pkg.sv
`default_nettype none
package scs_pkg;
	// Status register layout and reset image.
	localparam int STAT_W = 8;
	localparam int B_TXE = 7;
	localparam int B_RXF = 6;
	localparam int B_OVR = 5;
	localparam int B_FRM = 4;
	localparam int B_PAR = 3;
	localparam int B_TX_END_FLAG = 2;
	localparam int B_MPR = 1;
	localparam int B_MPT = 0;
	localparam int FLAG_LO = B_PAR;
	localparam logic [7:0] STAT_RESET = 8'h84;
	// Data path.
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int ASYNC_BITS = 10;
	localparam int SYNC_BITS = 8;
	// Timing: the system clock period and the bit time, in ns.
	localparam int CLK_PERIOD_NS = 50;
	localparam int BIT_TIME_NS = 8000;
	localparam int BIT_CYC = BIT_TIME_NS / CLK_PERIOD_NS;
	localparam int HALF_CYC = BIT_CYC / 2;
	localparam int EXT_OVERSAMPLE = 16;
	typedef enum logic {
		SCS_IDLE,
		SCS_SHIFT
	} scs_state_t;
endpackage
`default_nettype wire

// ### core/scs_core.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Transmit FIFO between the data writer and the shift register.
module scs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	// Filling side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Draining side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	logic [AW:0] nxt_count;
	logic full_ff;
	logic push;
	logic pop;

	assign push = in_valid && !full_ff;
	assign pop = out_valid && out_ready;
	assign in_ready = !full_ff;
	assign out_valid = (count_ff != '0);
	assign out_data = mem[rd_ptr_ff];
	assign nxt_count = count_ff + (AW + 1)'(push) - (AW + 1)'(pop);

	always_ff @(posedge clock) begin
		if (ce && push) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			full_ff <= 1'b0;
		end else if (ce) begin
			if (push) begin
				wr_ptr_ff <= wr_ptr_ff + AW'(1);
			end
			if (pop) begin
				rd_ptr_ff <= rd_ptr_ff + AW'(1);
			end
			count_ff <= nxt_count;
			full_ff <= (nxt_count == FULL);
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Operation
// - Transmit-end interrupt enable resets to 0, so no request until set.
// - Request drops when both empty and end flags clear, or enable clears; the code drops it when the end flag alone clears.
// - Both clock bits 0: internal clock; pin is port async, clock out sync.
// - High clock bit 1: external clock input; 11 and sync 01 are reserved.
// - Async internal with clock output drives the pin at the bit rate.
// - Status is 8 bits: empty, full, overrun, framing, parity, end, mp bits.
// - Status loads 0x84 on reset and on entry to low-power modes.
// - Five flags ignore writes of 1; 0 clears only after reading them as 1.
// - End and received mp bit are read-only; sent mp bit is read/write.
// - Empty flag sets when transmit disabled or a byte moves to the shifter.
// - Empty flag clears on a data write or a 0 write after reading 1.
// - End interrupt when no data is waiting as the last bit shifts out.
// - Empty flag stays 1 while disabled; enabled data write starts sending.
module scs_core
	import scs_pkg::*;
(
	// Clock, reset and freeze
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	// Control bits from the serial control register
	input wire logic transmit_enable,
	input wire logic tx_end_irq_enable,
	input wire logic clk_enable_hi,
	input wire logic clk_enable_lo,
	input wire logic sync_mode,
	input wire logic low_power_entry,
	// Status register access
	input wire logic stat_rd,
	input wire logic stat_wr,
	input wire logic [7:0] stat_wdata,
	output logic [7:0] serial_status,
	// Receive-side flag events
	input wire logic rx_full_set,
	input wire logic overrun_set,
	input wire logic framing_set,
	input wire logic parity_set,
	input wire logic mpb_rx_strobe,
	input wire logic mpb_rx_value,
	// Transmit data writes
	input wire logic tx_data_valid,
	input wire logic [7:0] tx_data,
	output logic tx_data_ready,
	// Link pins
	input wire logic serial_clock_pin_i,
	output logic serial_clock_pin_o,
	output logic serial_clock_pin_oe,
	output logic txd,
	output logic tx_end_irq
);
	logic [7:0] stat_ff;
	logic [7:FLAG_LO] armed_ff;
	logic te_q_ff;
	scs_state_t state_ff;
	logic [ASYNC_BITS-1:0] shreg_ff;
	logic [3:0] bits_left_ff;
	logic [7:0] div_ff;
	logic [4:0] ext_cnt_ff;
	logic sck_s1_ff;
	logic sck_s2_ff;
	logic sck_s3_ff;
	logic txd_ff;
	logic sck_o_ff;
	logic sck_oe_ff;
	logic irq_ff;
	logic fifo_full_n_ff;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic pop;
	logic push;
	logic tick;
	logic last_tick;
	logic ext_clk;
	logic int_async_out;
	logic int_sync_out;
	logic mode_ok;
	logic [7:FLAG_LO] clr;
	logic [7:0] nxt_stat;

	// Three-input guard: reserved settings keep the shifter from starting a frame.
	function automatic logic clk_mode_ok(input logic hi, input logic lo,
		input logic sy);
		clk_mode_ok = !(hi && lo) && !(sy && !hi && lo);
	endfunction

	assign ext_clk = clk_enable_hi;
	assign int_async_out = !sync_mode && !clk_enable_hi && clk_enable_lo;
	assign int_sync_out = sync_mode && !clk_enable_hi && !clk_enable_lo;
	assign mode_ok = clk_mode_ok(clk_enable_hi, clk_enable_lo, sync_mode);

	////////////////////////////////////////////////////////////////////////
	// Transmit FIFO; its ready is the writer's back-pressure.
	scs_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.ce(ce),
		.in_valid(tx_data_valid),
		.in_data(tx_data),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(pop)
	);

	assign push = tx_data_valid && fifo_in_ready;

	////////////////////////////////////////////////////////////////////////
	// Serial clock pin input synchroniser; the second and third stages are read for edge detection.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sck_s1_ff <= 1'b0;
			sck_s2_ff <= 1'b0;
			sck_s3_ff <= 1'b0;
		end else if (ce) begin
			sck_s1_ff <= serial_clock_pin_i;
			sck_s2_ff <= sck_s1_ff;
			sck_s3_ff <= sck_s2_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bit timing. The internal divider runs freely so the async clock
	// output keeps going between frames, as a receiver expects.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_ff <= '0;
		end else if (ce) begin
			if (div_ff == 8'(BIT_CYC - 1)) begin
				div_ff <= '0;
			end else begin
				div_ff <= div_ff + 8'h01;
			end
		end
	end

	// External async clock: sixteen rising edges make one bit.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ext_cnt_ff <= '0;
		end else if (ce) begin
			if (state_ff == SCS_IDLE) begin
				ext_cnt_ff <= '0;
			end else if (sck_s2_ff && !sck_s3_ff) begin
				if (ext_cnt_ff == 5'(EXT_OVERSAMPLE - 1)) begin
					ext_cnt_ff <= '0;
				end else begin
					ext_cnt_ff <= ext_cnt_ff + 5'h01;
				end
			end
		end
	end

	always_comb begin
		if (!ext_clk) begin
			tick = (div_ff == 8'(BIT_CYC - 1));
		end else if (sync_mode) begin
			tick = !sck_s2_ff && sck_s3_ff;
		end else begin
			tick = sck_s2_ff && !sck_s3_ff &&
				(ext_cnt_ff == 5'(EXT_OVERSAMPLE - 1));
		end
	end

	assign last_tick = (state_ff == SCS_SHIFT) && tick &&
		(bits_left_ff == 4'h1);
	// With the internal clock a frame only starts on a divider wrap. The
	// divider runs freely, so starting anywhere else would cut the start bit.
	assign pop = fifo_out_valid && transmit_enable && mode_ok &&
		(((state_ff == SCS_IDLE) && (ext_clk || tick)) || last_tick);

	////////////////////////////////////////////////////////////////////////
	// Shifter: async frames are start, eight data bits LSB first, stop.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= SCS_IDLE;
			shreg_ff <= '1;
			bits_left_ff <= '0;
			txd_ff <= 1'b1;
		end else if (ce) begin
			if (pop) begin
				state_ff <= SCS_SHIFT;
				if (sync_mode) begin
					shreg_ff <= {2'b11, fifo_out_data};
					bits_left_ff <= 4'(SYNC_BITS);
				end else begin
					shreg_ff <= {1'b1, fifo_out_data, 1'b0};
					bits_left_ff <= 4'(ASYNC_BITS);
				end
			end else if (!transmit_enable) begin
				state_ff <= SCS_IDLE;
				shreg_ff <= '1;
			end else if (state_ff == SCS_SHIFT && tick) begin
				shreg_ff <= {1'b1, shreg_ff[ASYNC_BITS-1:1]};
				bits_left_ff <= bits_left_ff - 4'h1;
				if (bits_left_ff == 4'h1) begin
					state_ff <= SCS_IDLE;
				end
			end
			txd_ff <= (state_ff == SCS_SHIFT) ? shreg_ff[0] : 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial clock pin drive.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sck_o_ff <= 1'b1;
			sck_oe_ff <= 1'b0;
		end else if (ce) begin
			sck_oe_ff <= int_async_out || int_sync_out;
			if (int_async_out) begin
				sck_o_ff <= (div_ff < 8'(HALF_CYC));
			end else if (int_sync_out && state_ff == SCS_SHIFT) begin
				sck_o_ff <= !(div_ff < 8'(HALF_CYC));
			end else begin
				sck_o_ff <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status register. Hardware sets win over software clears.
	assign clr = (stat_wr ? armed_ff & ~stat_wdata[7:FLAG_LO] : '0);

	always_comb begin
		nxt_stat = stat_ff;
		nxt_stat[7:FLAG_LO] = stat_ff[7:FLAG_LO] & ~clr;
		if (push) begin
			nxt_stat[B_TXE] = 1'b0;
			nxt_stat[B_TX_END_FLAG] = 1'b0;
		end
		if (pop || !transmit_enable) begin
			nxt_stat[B_TXE] = 1'b1;
		end
		if (last_tick && !pop) begin
			nxt_stat[B_TX_END_FLAG] = 1'b1;
		end
		if (rx_full_set) begin
			nxt_stat[B_RXF] = 1'b1;
		end
		if (overrun_set) begin
			nxt_stat[B_OVR] = 1'b1;
		end
		if (framing_set) begin
			nxt_stat[B_FRM] = 1'b1;
		end
		if (parity_set) begin
			nxt_stat[B_PAR] = 1'b1;
		end
		if (mpb_rx_strobe) begin
			nxt_stat[B_MPR] = mpb_rx_value;
		end
		if (stat_wr) begin
			nxt_stat[B_MPT] = stat_wdata[B_MPT];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stat_ff <= STAT_RESET;
			armed_ff <= '0;
		end else if (ce) begin
			if (low_power_entry) begin
				stat_ff <= STAT_RESET;
				armed_ff <= '0;
			end else begin
				stat_ff <= nxt_stat;
				if (stat_rd) begin
					armed_ff <= stat_ff[7:FLAG_LO];
				end else begin
					armed_ff <= armed_ff & ~clr;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq_ff <= 1'b0;
			fifo_full_n_ff <= 1'b0;
			te_q_ff <= 1'b0;
		end else if (ce) begin
			irq_ff <= tx_end_irq_enable && stat_ff[B_TX_END_FLAG];
			fifo_full_n_ff <= fifo_in_ready;
			te_q_ff <= transmit_enable;
		end
	end

	assign serial_status = stat_ff;
	assign tx_data_ready = fifo_in_ready;
	assign serial_clock_pin_o = sck_o_ff;
	assign serial_clock_pin_oe = sck_oe_ff;
	assign txd = txd_ff;
	assign tx_end_irq = irq_ff;
endmodule
`default_nettype wire

// ### verif/scs_sva.sv
`default_nettype none
module scs_sva
	import scs_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	// Control bits
	input wire logic transmit_enable,
	input wire logic tx_end_irq_enable,
	input wire logic clk_enable_hi,
	input wire logic clk_enable_lo,
	input wire logic sync_mode,
	input wire logic low_power_entry,
	// Status and events
	input wire logic stat_wr,
	input wire logic [7:0] serial_status,
	input wire logic rx_full_set,
	input wire logic mpb_rx_strobe,
	// Outputs under watch
	input wire logic serial_clock_pin_oe,
	input wire logic tx_end_irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_lp;
		ce && low_power_entry;
	endsequence
	sequence s_int_out;
		ce && !clk_enable_hi && clk_enable_lo && !sync_mode;
	endsequence
	a_lp_reload: assert property (
		s_lp |=> serial_status == STAT_RESET) else $error("no reload");
	a_irq_follow: assert property (
		ce |=> tx_end_irq == $past(tx_end_irq_enable && serial_status[2]))
		else $error("irq wrong");
	a_mpr_ro: assert property (
		ce && !mpb_rx_strobe && !low_power_entry |=>
		$stable(serial_status[1])) else $error("mp rx bit moved");
	a_rxf_no_set: assert property (
		ce && !serial_status[6] && !rx_full_set |=> !serial_status[6])
		else $error("rx full set by write");
	a_ovr_hold: assert property (
		ce && serial_status[5] && !stat_wr && !low_power_entry |=>
		serial_status[5]) else $error("overrun lost");
	a_txe_disabled: assert property (
		ce && !transmit_enable |=> serial_status[7])
		else $error("empty flag low while disabled");
	a_ext_input: assert property (
		ce && clk_enable_hi |=> !serial_clock_pin_oe)
		else $error("pin driven with external clock");
	a_clk_out: assert property (
		s_int_out |=> serial_clock_pin_oe) else $error("no clock output");
endmodule
////////////////////////////////////////
bind scs_core scs_sva chk_i (
	.clock(clock), .rst_n(rst_n), .ce(ce),
	.transmit_enable(transmit_enable),
	.tx_end_irq_enable(tx_end_irq_enable),
	.clk_enable_hi(clk_enable_hi), .clk_enable_lo(clk_enable_lo),
	.sync_mode(sync_mode), .low_power_entry(low_power_entry),
	.stat_wr(stat_wr), .serial_status(serial_status),
	.rx_full_set(rx_full_set), .mpb_rx_strobe(mpb_rx_strobe),
	.serial_clock_pin_oe(serial_clock_pin_oe), .tx_end_irq(tx_end_irq)
);
`default_nettype wire

// ### verif/scs_peer.sv
`default_nettype none
module scs_peer (
	// Control from the bench
	input wire logic run,
	// Clock onto the pin
	output logic sck
);
	timeunit 1ns;
	timeprecision 1ns;
	// The clock stands at 0 outside frames, so no stray edges are seen.
	initial sck = 1'h0;
	always #200 sck = run ? ~sck : 1'h0;
endmodule
`default_nettype wire

// ### verif/tb_serial_clock_select_and_status.sv
`default_nettype none
module tb_serial_clock_select_and_status import scs_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, rst_n, te, ie, hi, lo, sy, lp, rd, wr, rxs, vld, run;
	logic [7:0] wd, td, st;
	logic rdy, pin_o, pin_oe, txd, irq, sck;
	int fails = 0, n_compared = 0, cyc = 0, k, j;
	scs_core uut (
		.clock(clock), .rst_n(rst_n), .ce(1'h1),
		.transmit_enable(te), .tx_end_irq_enable(ie),
		.clk_enable_hi(hi), .clk_enable_lo(lo), .sync_mode(sy),
		.low_power_entry(lp), .stat_rd(rd), .stat_wr(wr),
		.stat_wdata(wd), .serial_status(st), .rx_full_set(rxs),
		.overrun_set(rxs), .framing_set(rxs), .parity_set(rxs),
		.mpb_rx_strobe(rxs), .mpb_rx_value(rxs), .tx_data_valid(vld),
		.tx_data(td), .tx_data_ready(rdy),
		.serial_clock_pin_i(pin_oe ? pin_o : sck),
		.serial_clock_pin_o(pin_o), .serial_clock_pin_oe(pin_oe),
		.txd(txd), .tx_end_irq(irq));
	scs_peer peer (.run(run), .sck(sck));
	always #25 clock = ~clock;
	////////////////////////////////////////
	task give_verdict;
		if (fails == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task tick;
		@(posedge clock);
		#1;
	endtask
	task chk(string nm, logic [7:0] e, logic [7:0] s);
		n_compared++;
		if (s !== e) begin
			$display("[ERR] %s exp %h got %h", nm, e, s);
			fails++;
		end
	endtask
	task sw(logic [7:0] d);
		wr = 1'h1;
		wd = d;
		tick;
		wr = 1'h0;
	endtask
	task sr;
		rd = 1'h1;
		tick;
		rd = 1'h0;
	endtask
	// The request stays up after ready is seen at an edge; the caller drops it.
	task push(logic [7:0] d);
		vld = 1'h1;
		td = d;
		for (k = 0; k < 40 && rdy !== 1'h1; k++)
			tick;
		tick;
	endtask
	task t_regs;
		chk("status", 8'h84, st);
		chk("irq", 8'h00, irq);
		sw(8'hff);
		chk("status", 8'h85, st);
		sw(8'h00);
		chk("status", 8'h84, st);
		te = 1'h1;
		sr;
		sw(8'h00);
		chk("status", 8'h04, st);
		te = 1'h0;
		tick;
		chk("status", 8'h84, st);
		rxs = 1'h1;
		tick;
		rxs = 1'h0;
		chk("status", 8'hfe, st);
		sw(8'h00);
		chk("status", 8'hfe, st);
		sr;
		sw(8'h00);
		chk("status", 8'h86, st);
		lp = 1'h1;
		tick;
		lp = 1'h0;
		chk("status", 8'h84, st);
	endtask
	task t_fifo;
		te = 1'h1;
		ie = 1'h1;
		hi = 1'h1;
		lo = 1'h1;
		for (j = 0; j < 16; j++)
			push(j[7:0]);
		chk("ready", 8'h00, rdy);
		vld = 1'h0;
		chk("status", 8'h00, st);
		lo = 1'h0;
		run = 1'h1;
		tick;
		tick;
		chk("pin_oe", 8'h00, pin_oe);
		for (k = 0; k < 25000 && st[2] !== 1'h1; k++)
			tick;
		run = 1'h0;
		tick;
		chk("irq", 8'h01, irq);
		chk("status", 8'h84, st);
		chk("ready", 8'h01, rdy);
	endtask
	task t_int;
		hi = 1'h0;
		lo = 1'h1;
		tick;
		tick;
		chk("pin_oe", 8'h01, pin_oe);
		push(8'ha5);
		vld = 1'h0;
		tick;
		chk("irq", 8'h00, irq);
		for (k = 0; k < 400 && txd !== 1'h0; k++)
			tick;
		repeat (BIT_CYC / 2) tick;
		chk("start", 8'h00, txd);
		for (j = 0; j < 8; j++) begin
			repeat (BIT_CYC) tick;
			chk("txd", {7'h0, td[j]}, txd);
		end
		repeat (BIT_CYC) tick;
		chk("stop", 8'h01, txd);
		for (k = 0; k < 400 && st[2] !== 1'h1; k++)
			tick;
		tick;
		chk("irq", 8'h01, irq);
		ie = 1'h0;
		tick;
		tick;
		chk("irq", 8'h00, irq);
	endtask
	task t_sync;
		lo = 1'h0;
		sy = 1'h1;
		tick;
		tick;
		chk("pin_oe", 8'h01, pin_oe);
		sy = 1'h0;
		tick;
		tick;
		chk("pin_oe", 8'h00, pin_oe);
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 40000) begin
			fails++;
			give_verdict;
		end
	end
	initial begin
		{clock, rst_n, te, ie, hi, lo, sy, lp, rd, wr, rxs, vld, run} = '0;
		wd = 8'h00;
		td = 8'h00;
		repeat (12) @(posedge clock);
		#1;
		rst_n = 1'h1;
		tick;
		t_regs;
		t_fifo;
		t_int;
		t_sync;
		give_verdict;
	end
endmodule
`default_nettype wire
